// [rtl/hpeq_map.vh]
`ifndef HPEQ_MAP_VH
`define HPEQ_MAP_VH
// register indices, byte address is four times the index
`define HPEQ_IDX_EQ        10'h118
`define HPEQ_IDX_LBAL_HI   10'h11a
`define HPEQ_IDX_LBAL_LO   10'h11b
`define HPEQ_IDX_RBAL_HI   10'h11c
`define HPEQ_IDX_RBAL_LO   10'h11d
`define HPEQ_IDX_VOL_HI    10'h11e
`define HPEQ_IDX_VOL_LO    10'h11f
`define HPEQ_IDX_STATUS    10'h130
// equalizer control fields
`define HPEQ_BAND_HI       10
`define HPEQ_BAND_LO       8
`define HPEQ_GAIN_HI       5
`define HPEQ_GAIN_LO       0
`define HPEQ_BAND_MAX      3'h6
`define HPEQ_GAIN_MAX      6'h30
`define HPEQ_GAIN_UNITY    7'h18
// writable bit masks, reserved bits store and read as zero
`define HPEQ_EQ_WMASK      16'h073f
`define HPEQ_HI_WMASK      16'h0fff
`define HPEQ_LO_WMASK      16'hffff
// reset values
`define HPEQ_EQ_RST        16'h0018
`define HPEQ_HI_RST        16'h0080
`define HPEQ_LO_RST        16'h0000
// band centres in hz
`define HPEQ_FC_B0         14'h0078
`define HPEQ_FC_B1         14'h00c8
`define HPEQ_FC_B2         14'h01f4
`define HPEQ_FC_B3         14'h04b0
`define HPEQ_FC_B4         14'h0bb8
`define HPEQ_FC_B5         14'h1d4c
`define HPEQ_FC_B6         14'h2ee0
// status fields
`define HPEQ_ST_RSVD       3
// bus answers
`define HPEQ_RESP_OKAY     2'h0
`define HPEQ_RESP_DECERR   2'h3
`endif

// [rtl/hpeq_coef.v]
`timescale 1ns/1ps
`include "hpeq_map.vh"
module hpeq_coef #(
    parameter CW = 28
) (
    // clock and reset
    input  wire          aclk,
    input  wire          aresetn,
    // half writes, data already masked
    input  wire          hi_we,
    input  wire [15:0]   hi_wdata,
    input  wire          lo_we,
    input  wire [15:0]   lo_wdata,
    // readback and state
    output reg  [15:0]   hi_q,
    output reg  [15:0]   lo_q,
    output wire          pend,
    // applied coefficient
    output reg  [CW-1:0] coef_q,
    output reg           upd_q
);
    localparam [15:0] HI_RST = `HPEQ_HI_RST;
    localparam [15:0] LO_RST = `HPEQ_LO_RST;

    reg         hi_seen_q;
    reg         lo_seen_q;
    wire [15:0] hi_d      = hi_we ? hi_wdata : hi_q;
    wire [15:0] lo_d      = lo_we ? lo_wdata : lo_q;
    wire        hi_seen_d = hi_seen_q | hi_we;
    wire        lo_seen_d = lo_seen_q | lo_we;
    wire        both      = hi_seen_d & lo_seen_d;

    assign pend = hi_seen_q | lo_seen_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            hi_q      <= HI_RST;
            lo_q      <= LO_RST;
            hi_seen_q <= 1'b0;
            lo_seen_q <= 1'b0;
            coef_q    <= {HI_RST[CW-17:0], LO_RST};
            upd_q     <= 1'b0;
        end else begin
            hi_q  <= hi_d;
            lo_q  <= lo_d;
            upd_q <= both;
            // a lone half waits, so the datapath never sees a torn word
            if (both) begin
                coef_q    <= {hi_d[CW-17:0], lo_d};
                hi_seen_q <= 1'b0;
                lo_seen_q <= 1'b0;
            end else begin
                hi_seen_q <= hi_seen_d;
                lo_seen_q <= lo_seen_d;
            end
        end
    end
endmodule

// [rtl/hpeq_regs.v]
`timescale 1ns/1ps
`include "hpeq_map.vh"
// Overview of operation
// - band field bits 10:8 picks centre
// - gain bits 5:0, half dB steps
// - eq register resets to 0x0018
// - coefficients are signed 5.23 values
// - left balance from 0x011A and 0x011B
// - right balance from 0x011C and 0x011D
// - volume from 0x011E and 0x011F
// - upper halves reset 0x0080, lower 0x0000
module hpeq_regs #(
    parameter CW = 28
) (
    // clock and reset
    input  wire                 aclk,
    input  wire                 aresetn,
    // axi4-lite write address
    input  wire [11:0]          s_axi_awaddr,
    input  wire                 s_axi_awvalid,
    output wire                 s_axi_awready,
    // axi4-lite write data
    input  wire [31:0]          s_axi_wdata,
    input  wire [3:0]           s_axi_wstrb,
    input  wire                 s_axi_wvalid,
    output wire                 s_axi_wready,
    // axi4-lite write response
    output wire [1:0]           s_axi_bresp,
    output wire                 s_axi_bvalid,
    input  wire                 s_axi_bready,
    // axi4-lite read address
    input  wire [11:0]          s_axi_araddr,
    input  wire                 s_axi_arvalid,
    output wire                 s_axi_arready,
    // axi4-lite read data
    output wire [31:0]          s_axi_rdata,
    output wire [1:0]           s_axi_rresp,
    output wire                 s_axi_rvalid,
    input  wire                 s_axi_rready,
    // equalizer settings
    output wire [2:0]           eq_band,
    output wire [5:0]           eq_gain,
    output wire [13:0]          eq_center_hz,
    output wire signed [6:0]    eq_gain_half_db,
    output wire                 eq_valid,
    // scaling coefficients, signed 5.23
    output wire signed [CW-1:0] left_balance_coef,
    output wire signed [CW-1:0] right_balance_coef,
    output wire signed [CW-1:0] volume_coef,
    output wire [2:0]           coef_update
);
    localparam NC = 3;
    // coefficient order: left balance, right balance, volume
    localparam [29:0] HI_IDXS = {`HPEQ_IDX_VOL_HI, `HPEQ_IDX_RBAL_HI, `HPEQ_IDX_LBAL_HI};
    localparam [29:0] LO_IDXS = {`HPEQ_IDX_VOL_LO, `HPEQ_IDX_RBAL_LO, `HPEQ_IDX_LBAL_LO};

    // bus state
    reg                 awready_q;
    reg                 wready_q;
    reg                 aw_full_q;
    reg                 w_full_q;
    reg  [9:0]          aw_idx_q;
    reg  [15:0]         w_data_q;
    reg  [1:0]          w_strb_q;
    reg                 bvalid_q;
    reg  [1:0]          bresp_q;
    reg                 arready_q;
    reg                 rvalid_q;
    reg  [31:0]         rdata_q;
    reg  [1:0]          rresp_q;

    // register state
    reg  [15:0]         eq_q;
    reg                 rsvd_err_q;
    reg  [2:0]          eq_band_q;
    reg  [5:0]          eq_gain_q;
    reg  [13:0]         eq_center_hz_q;
    reg  signed [6:0]   eq_gain_half_db_q;
    reg                 eq_valid_q;

    // combinational
    reg                 aw_full_d;
    reg                 w_full_d;
    reg  [31:0]         rdata_d;
    reg                 rd_map;
    reg                 wr_map;
    reg  [15:0]         wmask;
    integer             i;
    integer             j;

    wire                do_wr   = aw_full_q & w_full_q & ~bvalid_q;
    wire                aw_take = s_axi_awvalid & awready_q;
    wire                w_take  = s_axi_wvalid & wready_q;
    wire                ar_take = s_axi_arvalid & arready_q;
    wire [9:0]          ar_idx  = s_axi_araddr[11:2];
    wire [15:0]         lane    = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    wire                wr_eq   = do_wr & (aw_idx_q == `HPEQ_IDX_EQ);
    wire                wr_st   = do_wr & (aw_idx_q == `HPEQ_IDX_STATUS);

    wire [NC-1:0]       hi_we;
    wire [NC-1:0]       lo_we;
    wire [NC-1:0]       pend;
    wire [NC-1:0]       upd;
    wire [15:0]         hi_rd [0:NC-1];
    wire [15:0]         lo_rd [0:NC-1];
    wire [CW-1:0]       coef  [0:NC-1];

    // merge strobed bytes over old contents, then drop reserved bits
    function [15:0] merge;
        input [15:0] old;
        input [15:0] nw;
        input [15:0] ln;
        input [15:0] msk;
        begin
            merge = ((old & ~ln) | (nw & ln)) & msk;
        end
    endfunction

    genvar k;
    generate
        for (k = 0; k < NC; k = k + 1) begin : g_coef
            assign hi_we[k] = do_wr & (aw_idx_q == HI_IDXS[k*10 +: 10]);
            assign lo_we[k] = do_wr & (aw_idx_q == LO_IDXS[k*10 +: 10]);
            hpeq_coef #(
                .CW(CW)
            ) u_coef (
                .aclk     (aclk),
                .aresetn  (aresetn),
                .hi_we    (hi_we[k]),
                .hi_wdata (merge(hi_rd[k], w_data_q, lane, `HPEQ_HI_WMASK)),
                .lo_we    (lo_we[k]),
                .lo_wdata (merge(lo_rd[k], w_data_q, lane, `HPEQ_LO_WMASK)),
                .hi_q     (hi_rd[k]),
                .lo_q     (lo_rd[k]),
                .pend     (pend[k]),
                .coef_q   (coef[k]),
                .upd_q    (upd[k])
            );
        end
    endgenerate

    // write decode: mapped flag and writable mask of the target
    always @* begin
        wr_map = 1'b0;
        wmask  = 16'h0000;
        if (aw_idx_q == `HPEQ_IDX_EQ) begin
            wr_map = 1'b1;
            wmask  = `HPEQ_EQ_WMASK;
        end
        if (aw_idx_q == `HPEQ_IDX_STATUS) begin
            wr_map = 1'b1;
            wmask  = 16'hffff;
        end
        for (i = 0; i < NC; i = i + 1) begin
            if (aw_idx_q == HI_IDXS[i*10 +: 10]) begin
                wr_map = 1'b1;
                wmask  = `HPEQ_HI_WMASK;
            end
            if (aw_idx_q == LO_IDXS[i*10 +: 10]) begin
                wr_map = 1'b1;
                wmask  = `HPEQ_LO_WMASK;
            end
        end
    end

    // address and data may arrive in either order
    always @* begin
        aw_full_d = aw_full_q;
        w_full_d  = w_full_q;
        if (aw_take) begin
            aw_full_d = 1'b1;
        end
        if (w_take) begin
            w_full_d = 1'b1;
        end
        if (do_wr) begin
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            aw_idx_q  <= 10'h000;
            w_data_q  <= 16'h0000;
            w_strb_q  <= 2'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `HPEQ_RESP_OKAY;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            awready_q <= ~aw_full_d;
            wready_q  <= ~w_full_d;
            if (aw_take) begin
                aw_idx_q <= s_axi_awaddr[11:2];
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata[15:0];
                w_strb_q <= s_axi_wstrb[1:0];
            end
            if (do_wr) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_map ? `HPEQ_RESP_OKAY : `HPEQ_RESP_DECERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // equalizer control and reserved-bit watch
    always @(posedge aclk) begin
        if (!aresetn) begin
            eq_q       <= `HPEQ_EQ_RST;
            rsvd_err_q <= 1'b0;
        end else begin
            if (wr_eq) begin
                eq_q <= merge(eq_q, w_data_q, lane, `HPEQ_EQ_WMASK);
            end
            // host must keep reserved bits zero; a slip is only flagged
            if (do_wr & wr_map & ~wr_st & |(w_data_q & lane & ~wmask)) begin
                rsvd_err_q <= 1'b1;
            end else if (wr_st & w_strb_q[0] & w_data_q[`HPEQ_ST_RSVD]) begin
                rsvd_err_q <= 1'b0;
            end
        end
    end

    // decoded eq settings, one cycle behind the register
    always @(posedge aclk) begin
        if (!aresetn) begin
            eq_band_q         <= 3'h0;
            eq_gain_q         <= 6'h00;
            eq_center_hz_q    <= `HPEQ_FC_B0;
            eq_gain_half_db_q <= 7'h00;
            eq_valid_q        <= 1'b0;
        end else begin
            eq_band_q         <= eq_q[`HPEQ_BAND_HI:`HPEQ_BAND_LO];
            eq_gain_q         <= eq_q[`HPEQ_GAIN_HI:`HPEQ_GAIN_LO];
            // code 0x00 is +24 half dB, 0x18 is zero, 0x30 is -24
            eq_gain_half_db_q <= `HPEQ_GAIN_UNITY - {1'b0, eq_q[`HPEQ_GAIN_HI:`HPEQ_GAIN_LO]};
            eq_valid_q        <= (eq_q[`HPEQ_BAND_HI:`HPEQ_BAND_LO] <= `HPEQ_BAND_MAX) &
                                 (eq_q[`HPEQ_GAIN_HI:`HPEQ_GAIN_LO] <= `HPEQ_GAIN_MAX);
            case (eq_q[`HPEQ_BAND_HI:`HPEQ_BAND_LO])
                3'h0: begin
                    eq_center_hz_q <= `HPEQ_FC_B0;
                end
                3'h1: begin
                    eq_center_hz_q <= `HPEQ_FC_B1;
                end
                3'h2: begin
                    eq_center_hz_q <= `HPEQ_FC_B2;
                end
                3'h3: begin
                    eq_center_hz_q <= `HPEQ_FC_B3;
                end
                3'h4: begin
                    eq_center_hz_q <= `HPEQ_FC_B4;
                end
                3'h5: begin
                    eq_center_hz_q <= `HPEQ_FC_B5;
                end
                3'h6: begin
                    eq_center_hz_q <= `HPEQ_FC_B6;
                end
                default: begin
                    // code 7 has no band; eq_valid drops
                    eq_center_hz_q <= 14'h0000;
                end
            endcase
        end
    end

    // read decode, upper lanes read as zero
    always @* begin
        rdata_d = 32'h0000_0000;
        rd_map  = 1'b0;
        if (ar_idx == `HPEQ_IDX_EQ) begin
            rdata_d = {16'h0000, eq_q};
            rd_map  = 1'b1;
        end
        if (ar_idx == `HPEQ_IDX_STATUS) begin
            rdata_d = {28'h0000000, rsvd_err_q, pend};
            rd_map  = 1'b1;
        end
        for (j = 0; j < NC; j = j + 1) begin
            if (ar_idx == HI_IDXS[j*10 +: 10]) begin
                rdata_d = {16'h0000, hi_rd[j]};
                rd_map  = 1'b1;
            end
            if (ar_idx == LO_IDXS[j*10 +: 10]) begin
                rdata_d = {16'h0000, lo_rd[j]};
                rd_map  = 1'b1;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `HPEQ_RESP_OKAY;
        end else begin
            if (ar_take) begin
                arready_q <= 1'b0;
                rvalid_q  <= 1'b1;
                rdata_q   <= rdata_d;
                rresp_q   <= rd_map ? `HPEQ_RESP_OKAY : `HPEQ_RESP_DECERR;
            end else if (rvalid_q & s_axi_rready) begin
                rvalid_q  <= 1'b0;
                arready_q <= 1'b1;
            end else if (!rvalid_q) begin
                arready_q <= 1'b1;
            end
        end
    end

    // port drive, all from flip-flops
    assign s_axi_awready      = awready_q;
    assign s_axi_wready       = wready_q;
    assign s_axi_bvalid       = bvalid_q;
    assign s_axi_bresp        = bresp_q;
    assign s_axi_arready      = arready_q;
    assign s_axi_rvalid       = rvalid_q;
    assign s_axi_rdata        = rdata_q;
    assign s_axi_rresp        = rresp_q;
    assign eq_band            = eq_band_q;
    assign eq_gain            = eq_gain_q;
    assign eq_center_hz       = eq_center_hz_q;
    assign eq_gain_half_db    = eq_gain_half_db_q;
    assign eq_valid           = eq_valid_q;
    assign left_balance_coef  = coef[0];
    assign right_balance_coef = coef[1];
    assign volume_coef        = coef[2];
    assign coef_update        = upd;
endmodule

// [test/hpeq_regs_assertions.sv]
`timescale 1ns/1ps
module hpeq_chk #(
    parameter CW = 28
) (
    // clock and reset
    input wire                 aclk,
    input wire                 aresetn,
    // write response
    input wire [1:0]           s_axi_bresp,
    input wire                 s_axi_bvalid,
    input wire                 s_axi_bready,
    // equalizer
    input wire [2:0]           eq_band,
    input wire [5:0]           eq_gain,
    input wire [13:0]          eq_center_hz,
    input wire signed [6:0]    eq_gain_half_db,
    input wire                 eq_valid,
    // coefficients
    input wire signed [CW-1:0] left_balance_coef,
    input wire signed [CW-1:0] right_balance_coef,
    input wire signed [CW-1:0] volume_coef,
    input wire [2:0]           coef_update
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_band6; eq_band == 3'h6 |-> eq_center_hz == 14'h2ee0; endproperty
    a_band6: assert property (p_band6) else $error("band six centre wrong");
    property p_gain; eq_valid |-> eq_gain_half_db + $signed({1'b0, eq_gain}) == 7'sd24; endproperty
    a_gain: assert property (p_gain) else $error("gain step wrong");
    property p_inval; eq_gain > 6'h30 |-> !eq_valid; endproperty
    a_inval: assert property (p_inval) else $error("gain out of range kept valid");
    property p_rst; $rose(aresetn) |=> eq_gain == 6'h18 && eq_band == 3'h0; endproperty
    a_rst: assert property (p_rst) else $error("eq reset value wrong");
    property p_unity;
        $rose(aresetn) |-> left_balance_coef == 28'h0800000 && right_balance_coef == 28'h0800000
            && volume_coef == 28'h0800000;
    endproperty
    a_unity: assert property (p_unity) else $error("coefficient not unity");
    // a one-edge reset would change a coefficient without a pulse
    property p_left; $past(aresetn) && $changed(left_balance_coef) |-> coef_update[0]; endproperty
    a_left: assert property (p_left) else $error("left changed silently");
    property p_right; $past(aresetn) && $changed(right_balance_coef) |-> coef_update[1]; endproperty
    a_right: assert property (p_right) else $error("right changed silently");
    property p_vol; $past(aresetn) && $changed(volume_coef) |-> coef_update[2]; endproperty
    a_vol: assert property (p_vol) else $error("volume changed silently");
    property p_upd; |coef_update |-> s_axi_bvalid && s_axi_bresp == 2'h0; endproperty
    a_upd: assert property (p_upd) else $error("apply without write");

    c_dec: cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
    c_vol: cover property (coef_update[2]);
    c_wait: cover property (s_axi_bvalid && !s_axi_bready);
endmodule

bind hpeq_regs hpeq_chk #(.CW(CW)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .eq_band(eq_band), .eq_gain(eq_gain), .eq_center_hz(eq_center_hz),
    .eq_gain_half_db(eq_gain_half_db), .eq_valid(eq_valid),
    .left_balance_coef(left_balance_coef), .right_balance_coef(right_balance_coef),
    .volume_coef(volume_coef), .coef_update(coef_update)
);

// [test/hpeq_host.sv]
`timescale 1ns/1ps
module hpeq_host (
    // clock
    input  wire         aclk,
    // write channels
    output logic [11:0] awaddr,
    output logic        awvalid,
    input  wire         awready,
    output logic [31:0] wdata,
    output logic [3:0]  wstrb,
    output logic        wvalid,
    input  wire         wready,
    input  wire         bvalid,
    output logic        bready,
    // read channels
    output logic [11:0] araddr,
    output logic        arvalid,
    input  wire         arready,
    input  wire         rvalid,
    output logic        rready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    end

    // released address and data lines show the inverse so a stale value is never mistaken; wstrb keeps its value
    task automatic wr(input logic [9:0] idx, input logic [15:0] d);
        logic aw, w;
        @(posedge aclk);
        awaddr  <= {idx, 2'b00};
        wdata   <= {16'h0000, d};
        wstrb   <= 4'h3;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        aw = 1'b1;
        w  = 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && awready) begin
                aw = 1'b0;
                awvalid <= 1'b0;
                awaddr  <= ~awaddr;
            end
            if (w && wready) begin
                w = 1'b0;
                wvalid <= 1'b0;
                wdata  <= ~wdata;
            end
        end
        repeat ($urandom % 3) @(posedge aclk);
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] idx);
        @(posedge aclk);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        araddr  <= ~araddr;
        repeat ($urandom % 3) @(posedge aclk);
        rready <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
    endtask
endmodule

// [test/test_headphone_eq_balance_volume_regs.sv]
`timescale 1ns/1ps
`include "hpeq_map.vh"
module test_headphone_eq_balance_volume_regs;
    logic               aclk = 1'b0;
    logic               aresetn = 1'b0;
    logic [11:0]        awaddr, araddr;
    logic [31:0]        wdata, rdata;
    logic [3:0]         wstrb;
    logic [1:0]         bresp, rresp;
    logic               awvalid, awready, wvalid, wready, bvalid, bready;
    logic               arvalid, arready, rvalid, rready, ok;
    logic [2:0]         band, upd;
    logic [5:0]         gain;
    logic [13:0]        fc;
    logic signed [6:0]  hdb;
    logic signed [27:0] lcoef, rcoef, vcoef;
    logic [13:0]        fcs[7] = '{14'h0078, 14'h00c8, 14'h01f4, 14'h04b0, 14'h0bb8, 14'h1d4c, 14'h2ee0};
    logic [33:0]        rq[$];
    logic [1:0]         bq[$];
    int                 mismatches = 0;
    int                 n_tests = 0;

    always #2 aclk = ~aclk;

    hpeq_regs #(.CW(28)) DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .eq_band(band), .eq_gain(gain), .eq_center_hz(fc), .eq_gain_half_db(hdb), .eq_valid(ok),
        .left_balance_coef(lcoef), .right_balance_coef(rcoef), .volume_coef(vcoef),
        .coef_update(upd)
    );

    hpeq_host host (
        .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rvalid(rvalid), .rready(rready)
    );

    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [15:0] d, input logic [1:0] r);
        bq.push_back(r);
        host.wr(idx, d);
    endtask

    task automatic rd(input logic [9:0] idx, input logic [15:0] e, input logic [1:0] r);
        rq.push_back({r, 16'h0000, e});
        host.rd(idx);
    endtask

    function automatic logic [27:0] coef(input int k);
        return k == 0 ? lcoef : k == 1 ? rcoef : vcoef;
    endfunction

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // results are compared in the order they were requested
    always @(posedge aclk) begin
        if (bvalid && bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
        if (rvalid && rready) chk("rdata", rq.pop_front(), {rresp, rdata});
    end

    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        tally_and_finish;
    end

    initial begin
        logic [27:0] v;
        logic [9:0]  hi;
        logic [5:0]  g;
        logic [6:0]  e7;
        void'($urandom(32'h9b20d985));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("gain", 34'h18, 34'(gain));
        for (int i = 0; i < 7; i++) begin
            rd(`HPEQ_IDX_EQ + 10'(i + (i > 0)), i == 0 ? 16'h0018 : i % 2 ? 16'h0080 : 16'h0000, 2'h0);
        end
        for (int b = 0; b < 7; b++) begin
            g = b == 0 ? 6'h00 : b == 6 ? 6'h30 : 6'($urandom % 49);
            e7 = 7'h18 - {1'b0, g};
            wr(`HPEQ_IDX_EQ, {5'h00, 3'(b), 2'b00, g}, 2'h0);
            rd(`HPEQ_IDX_EQ, {5'h00, 3'(b), 2'b00, g}, 2'h0);
            chk("band", 34'(b), 34'(band));
            chk("centre", 34'(fcs[b]), 34'(fc));
            chk("half_db", 34'(e7), 34'($unsigned(hdb)));
        end
        // reserved bits set on purpose: they must read back as zero
        wr(`HPEQ_IDX_EQ, 16'hffff, 2'h0);
        rd(`HPEQ_IDX_EQ, 16'h073f, 2'h0);
        chk("valid", 34'h0, 34'(ok));
        rd(`HPEQ_IDX_STATUS, 16'h0008, 2'h0);
        wr(`HPEQ_IDX_STATUS, 16'h0008, 2'h0);
        rd(`HPEQ_IDX_STATUS, 16'h0000, 2'h0);
        // odd coefficient takes its low half first
        for (int k = 0; k < 3; k++) begin
            hi = `HPEQ_IDX_LBAL_HI + 10'(2 * k);
            v = 28'($urandom);
            wr(hi + 10'(k == 1), k == 1 ? v[15:0] : {4'h0, v[27:16]}, 2'h0);
            chk("half", 34'h0800000, 34'(coef(k)));
            rd(`HPEQ_IDX_STATUS, 16'(1 << k), 2'h0);
            wr(hi + 10'(k != 1), k == 1 ? {4'h0, v[27:16]} : v[15:0], 2'h0);
            chk("coef", 34'(v), 34'(coef(k)));
            rd(hi, {4'h0, v[27:16]}, 2'h0);
            rd(hi + 10'h001, v[15:0], 2'h0);
        end
        wr(10'h121, 16'h1234, 2'h3);
        rd(10'h121, 16'h0000, 2'h3);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`HPEQ_IDX_EQ, 16'h0018, 2'h0);
        chk("vol", 34'h0800000, 34'(vcoef));
        @(posedge aclk);
        tally_and_finish;
    end
endmodule
